// >>> core/dsp_pkg.sv
// Purpose: Constants for the dual-slope 16-bit PWM block
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: Offsets are byte addresses
package dsp_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMPA = 8'h04;
  localparam logic [7:0] ADDR_CMPB = 8'h08;
  localparam logic [7:0] ADDR_CAPT = 8'h0C;
  localparam logic [7:0] ADDR_CNT = 8'h10;
  localparam logic [7:0] ADDR_FLAG = 8'h14;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [3:0] WGM_PC8 = 4'h1;
  localparam logic [3:0] WGM_PC9 = 4'h2;
  localparam logic [3:0] WGM_PC10 = 4'h3;
  localparam logic [3:0] WGM_PFC_CAP = 4'h8;
  localparam logic [3:0] WGM_PFC_CMPA = 4'h9;
  localparam logic [3:0] WGM_PC_CAP = 4'hA;
  localparam logic [3:0] WGM_PC_CMPA = 4'hB;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_NONINV = 2'h2;
  localparam logic [1:0] COM_INV = 2'h3;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] PS_8 = 10'h007;
  localparam logic [9:0] PS_64 = 10'h03F;
  localparam logic [9:0] PS_256 = 10'h0FF;
  localparam logic [9:0] PS_1024 = 10'h3FF;
  // Control word fields
  localparam int CTRL_WGM_LSB = 0;
  localparam int CTRL_COMA_LSB = 4;
  localparam int CTRL_COMB_LSB = 6;
  localparam int CTRL_CS_LSB = 8;
  localparam int CTRL_DIRA_BIT = 12;
  localparam int CTRL_DIRB_BIT = 13;
  // Flag word fields, write one to clear
  localparam int FLG_OVF = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FLG_CAPT = 3;
endpackage : dsp_pkg

// >>> core/dsp_pwm16.sv
// Purpose: Dual-slope 16-bit PWM timer with AHB-Lite register access
// Assumes: One clock, port logic outside handles pins with disconnected compare outputs
// Notes: How it works
// How it works
// - Phase correct counter runs up from zero to top, then down, forever.
// - Phase correct top is fixed 8/9/10-bit, capture register, or compare A.
// - Counter stays at top one timer cycle before counting down.
// - Non-inverting clears on up match, sets on down match; inverting opposite.
// - Output mode two is non-inverted, three is inverted PWM.
// - Phase correct overflow flag sets whenever the counter reaches zero.
// - Phase correct compares load at top; top source flag sets then.
// - Compare zero gives constant low, compare top constant high, non-inverted.
// - Fixed top masks unused compare bits to zero on write.
// - Frequency correct top is capture register (8) or compare A (9).
// - Frequency correct compares load at zero with the overflow flag.
// - Frequency correct sets the top source flag at top.
// - Each channel match sets that channel's compare flag.
// - Pin driver is enabled only when the direction bit says output.
// - Timer clock is I/O clock divided by 1, 8, 64, 256 or 1024.
// - Capture top is unbuffered; compare A is double buffered.
// - Output mode one toggles A when mode MSB set, else disconnected.
// - Output mode zero disconnects the compare output.
`timescale 1ns/1ps
module dsp_pwm16 (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic hready,
  // Compare output pins
  output logic compare_output_a,
  output logic compare_output_a_oe_n,
  output logic compare_output_b,
  output logic compare_output_b_oe_n
);
  logic rst_s1_reg, rst_s2_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rstn = rst_s2_reg;

  // Bus address phase capture
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  wire phase_ok = hsel && htrans[1] && hready;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= phase_ok && hwrite;
      if (phase_ok) addr_reg <= haddr[7:0];
    end
  end
  wire wr_ctrl = wr_pend_reg && addr_reg == dsp_pkg::ADDR_CTRL;
  wire wr_cmpa = wr_pend_reg && addr_reg == dsp_pkg::ADDR_CMPA;
  wire wr_cmpb = wr_pend_reg && addr_reg == dsp_pkg::ADDR_CMPB;
  wire wr_capt = wr_pend_reg && addr_reg == dsp_pkg::ADDR_CAPT;
  wire wr_cnt = wr_pend_reg && addr_reg == dsp_pkg::ADDR_CNT;
  wire wr_flag = wr_pend_reg && addr_reg == dsp_pkg::ADDR_FLAG;

  // Control register
  logic [13:0] ctrl_reg;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) ctrl_reg <= 14'h0000;
    else if (wr_ctrl) ctrl_reg <= hwdata[13:0];
  end
  wire [3:0] waveform_mode = ctrl_reg[dsp_pkg::CTRL_WGM_LSB +: 4];
  wire waveform_mode_msb = waveform_mode[3];
  wire [1:0] com_a = ctrl_reg[dsp_pkg::CTRL_COMA_LSB +: 2];
  wire [1:0] com_b = ctrl_reg[dsp_pkg::CTRL_COMB_LSB +: 2];
  wire [2:0] clk_sel = ctrl_reg[dsp_pkg::CTRL_CS_LSB +: 3];
  wire pin_direction_bit_a = ctrl_reg[dsp_pkg::CTRL_DIRA_BIT];
  wire pin_direction_bit_b = ctrl_reg[dsp_pkg::CTRL_DIRB_BIT];

  // Mode decode
  wire mode_pfc = waveform_mode == dsp_pkg::WGM_PFC_CAP ||
                  waveform_mode == dsp_pkg::WGM_PFC_CMPA;
  wire mode_pc = waveform_mode == dsp_pkg::WGM_PC8 || waveform_mode == dsp_pkg::WGM_PC9 ||
                 waveform_mode == dsp_pkg::WGM_PC10 || waveform_mode == dsp_pkg::WGM_PC_CAP ||
                 waveform_mode == dsp_pkg::WGM_PC_CMPA;
  wire top_cap = waveform_mode == dsp_pkg::WGM_PC_CAP || waveform_mode == dsp_pkg::WGM_PFC_CAP;
  wire top_cmpa = waveform_mode == dsp_pkg::WGM_PC_CMPA ||
                  waveform_mode == dsp_pkg::WGM_PFC_CMPA;

  // Prescaler
  logic [9:0] ps_cnt_reg;
  logic [9:0] ps_lim;
  always_comb begin
    unique case (clk_sel)
      dsp_pkg::CS_DIV8: ps_lim = dsp_pkg::PS_8;
      dsp_pkg::CS_DIV64: ps_lim = dsp_pkg::PS_64;
      dsp_pkg::CS_DIV256: ps_lim = dsp_pkg::PS_256;
      dsp_pkg::CS_DIV1024: ps_lim = dsp_pkg::PS_1024;
      default: ps_lim = 10'h000;
    endcase
  end
  wire ps_run = clk_sel != dsp_pkg::CS_STOP && clk_sel <= dsp_pkg::CS_DIV1024;
  wire tick = ps_run && ps_cnt_reg >= ps_lim;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) ps_cnt_reg <= 10'h000;
    else if (!ps_run || tick) ps_cnt_reg <= 10'h000;
    else ps_cnt_reg <= ps_cnt_reg + 10'h001;
  end

  // Compare and top registers
  logic [15:0] cmpa_buf_reg, cmpb_buf_reg, cmpa_reg, cmpb_reg;
  logic [15:0] capture_top_value, timer_count;
  logic count_down_reg;
  logic [15:0] top_value;
  always_comb begin
    unique case (waveform_mode)
      dsp_pkg::WGM_PC8: top_value = dsp_pkg::TOP_8BIT;
      dsp_pkg::WGM_PC9: top_value = dsp_pkg::TOP_9BIT;
      dsp_pkg::WGM_PC10: top_value = dsp_pkg::TOP_10BIT;
      default: top_value = top_cap ? capture_top_value : cmpa_reg;
    endcase
  end
  wire [15:0] wmask = (waveform_mode == dsp_pkg::WGM_PC8) ? dsp_pkg::TOP_8BIT :
                      (waveform_mode == dsp_pkg::WGM_PC9) ? dsp_pkg::TOP_9BIT :
                      (waveform_mode == dsp_pkg::WGM_PC10) ? dsp_pkg::TOP_10BIT : 16'hFFFF;
  wire [15:0] wr_cmp_val = hwdata[15:0] & wmask;
  wire at_top = timer_count == top_value;
  wire at_bot = timer_count == dsp_pkg::BOTTOM;
  wire dual = mode_pc || mode_pfc;
  wire load_cmp = tick && dual && (mode_pc ? at_top : at_bot);
  wire match_a = tick && timer_count == cmpa_reg;
  wire match_b = tick && timer_count == cmpb_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmpa_buf_reg <= 16'h0000;
      cmpb_buf_reg <= 16'h0000;
      cmpa_reg <= 16'h0000;
      cmpb_reg <= 16'h0000;
      capture_top_value <= 16'h0000;
    end else begin
      if (wr_cmpa) cmpa_buf_reg <= wr_cmp_val;
      if (wr_cmpb) cmpb_buf_reg <= wr_cmp_val;
      if (wr_capt) capture_top_value <= hwdata[15:0];
      if (!dual) begin
        if (wr_cmpa) cmpa_reg <= wr_cmp_val;
        if (wr_cmpb) cmpb_reg <= wr_cmp_val;
      end else if (load_cmp) begin
        cmpa_reg <= cmpa_buf_reg;
        cmpb_reg <= cmpb_buf_reg;
      end
    end
  end

  // Counter with direction
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer_count <= 16'h0000;
      count_down_reg <= 1'b0;
    end else if (wr_cnt) begin
      timer_count <= hwdata[15:0];
    end else if (tick && dual) begin
      if (at_top) begin
        count_down_reg <= 1'b1;
        timer_count <= timer_count - 16'h0001;
      end else if (at_bot) begin
        count_down_reg <= 1'b0;
        timer_count <= timer_count + 16'h0001;
      end else if (count_down_reg) begin
        timer_count <= timer_count - 16'h0001;
      end else begin
        timer_count <= timer_count + 16'h0001;
      end
    end
  end

  // Flags, set wins over clear
  logic [3:0] flag_reg;
  wire [3:0] flag_set;
  assign flag_set[dsp_pkg::FLG_OVF] = tick && dual && at_bot;
  assign flag_set[dsp_pkg::FLG_CMPA] = match_a || (tick && dual && top_cmpa && at_top);
  assign flag_set[dsp_pkg::FLG_CMPB] = match_b;
  assign flag_set[dsp_pkg::FLG_CAPT] = tick && dual && top_cap && at_top;
  wire [3:0] flag_clr = wr_flag ? hwdata[3:0] : 4'h0;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) flag_reg <= 4'h0;
    else flag_reg <= flag_set | (flag_reg & ~flag_clr);
  end

  // Waveform registers
  logic wave_a_reg, wave_b_reg;
  // A match at top counts as the turn to down-counting, so compare equal to top stays high
  wire dir_up = at_bot || (!count_down_reg && !at_top);
  function automatic logic wave_next(input logic cur, input logic [1:0] com, input logic hit,
                                     input logic up, input logic tog_ok);
    logic v;
    v = cur;
    if (hit) begin
      if (com == dsp_pkg::COM_NONINV) v = !up;
      else if (com == dsp_pkg::COM_INV) v = up;
      else if (com == dsp_pkg::COM_TOGGLE && tog_ok) v = !cur;
    end
    return v;
  endfunction : wave_next
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wave_a_reg <= 1'b0;
      wave_b_reg <= 1'b0;
    end else if (dual) begin
      wave_a_reg <= wave_next(wave_a_reg, com_a, match_a, dir_up, waveform_mode_msb);
      wave_b_reg <= wave_next(wave_b_reg, com_b, match_b, dir_up, 1'b0);
    end
  end

  // Pin drive
  wire conn_a = com_a[1] || (com_a == dsp_pkg::COM_TOGGLE && waveform_mode_msb);
  wire conn_b = com_b[1];
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      compare_output_a <= 1'b0;
      compare_output_b <= 1'b0;
      compare_output_a_oe_n <= 1'b1;
      compare_output_b_oe_n <= 1'b1;
    end else begin
      compare_output_a <= wave_next(wave_a_reg, com_a, match_a && dual, dir_up, waveform_mode_msb);
      compare_output_b <= wave_next(wave_b_reg, com_b, match_b && dual, dir_up, 1'b0);
      compare_output_a_oe_n <= !(conn_a && pin_direction_bit_a);
      compare_output_b_oe_n <= !(conn_b && pin_direction_bit_b);
    end
  end

  // Read mux, taken from the address phase so data stands through the data phase
  wire [7:0] rd_addr = haddr[7:0];
  wire [31:0] rd_mux =
    (rd_addr == dsp_pkg::ADDR_CTRL) ? {18'h00000, ctrl_reg} :
    (rd_addr == dsp_pkg::ADDR_CMPA) ? {16'h0000, cmpa_buf_reg} :
    (rd_addr == dsp_pkg::ADDR_CMPB) ? {16'h0000, cmpb_buf_reg} :
    (rd_addr == dsp_pkg::ADDR_CAPT) ? {16'h0000, capture_top_value} :
    (rd_addr == dsp_pkg::ADDR_CNT) ? {16'h0000, timer_count} :
    (rd_addr == dsp_pkg::ADDR_FLAG) ? {28'h0000000, flag_reg} : 32'h00000000;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      if (phase_ok && !hwrite) hrdata <= rd_mux;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule : dsp_pwm16

// >>> tb/dsp_load.sv
// Purpose: Load on the compare pins
// Assumes: Pull-down on each pin
// Notes: Undriven pin reads low
`timescale 1ns/1ps
module dsp_load (
  // Driver side
  input wire logic out_a,
  input wire logic out_a_oe_n,
  input wire logic out_b,
  input wire logic out_b_oe_n,
  // Pin levels
  output logic pin_a,
  output logic pin_b
);
  assign pin_a = out_a_oe_n ? 1'b0 : out_a;
  assign pin_b = out_b_oe_n ? 1'b0 : out_b;
endmodule : dsp_load

// >>> tb/dsp_pwm16_chk.sv
// Purpose: Port checker for the dual-slope PWM block
// Assumes: Control word shadowed from bus writes
// Notes: Bound into every dsp_pwm16
`timescale 1ns/1ps
module dsp_pwm16_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins
  input wire logic compare_output_a,
  input wire logic compare_output_a_oe_n,
  input wire logic compare_output_b,
  input wire logic compare_output_b_oe_n
);
  logic wq_reg;
  logic [7:0] aq_reg;
  logic [31:0] ctl_reg;
  logic [1:0] sw_reg;
  wire ap = hsel && htrans[1] && hready;
  wire rd = ap && !hwrite;
  wire quiet = sw_reg == 2'h3;
  wire stop = ctl_reg[dsp_pkg::CTRL_CS_LSB +: 3] == dsp_pkg::CS_STOP;
  wire [1:0] ca = ctl_reg[dsp_pkg::CTRL_COMA_LSB +: 2];
  wire [1:0] cb = ctl_reg[dsp_pkg::CTRL_COMB_LSB +: 2];
  wire en_a = ctl_reg[dsp_pkg::CTRL_DIRA_BIT] && (ca[1] || (ca == 2'h1 && ctl_reg[3]));
  wire en_b = ctl_reg[dsp_pkg::CTRL_DIRB_BIT] && cb[1];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wq_reg <= 1'b0;
      aq_reg <= 8'h00;
      ctl_reg <= 32'h0;
      sw_reg <= 2'h3;
    end else begin
      wq_reg <= ap && hwrite;
      aq_reg <= haddr[7:0];
      if (wq_reg && aq_reg == dsp_pkg::ADDR_CTRL) ctl_reg <= hwdata;
      sw_reg <= wq_reg ? 2'h0 : (quiet ? sw_reg : sw_reg + 2'h1);
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_OKAY: assert property (hresp == 1'b0) else $error("hresp not okay");
  AST_READY: assert property (hreadyout) else $error("hreadyout low");
  AST_OE_A: assert property (quiet |-> compare_output_a_oe_n == !en_a)
    else $error("pin A enable wrong");
  AST_OE_B: assert property (quiet |-> compare_output_b_oe_n == !en_b)
    else $error("pin B enable wrong");
  AST_STOP_A: assert property (quiet && stop |-> $stable(compare_output_a))
    else $error("output A moved while stopped");
  AST_STOP_B: assert property (quiet && stop |-> $stable(compare_output_b))
    else $error("output B moved while stopped");
  AST_RDATA: assert property ($changed(hrdata) |-> $past(rd) || $past(rd, 2))
    else $error("hrdata changed without read");
  AST_RST_OE: assert property ($rose(rst_n) |-> compare_output_a_oe_n && compare_output_b_oe_n)
    else $error("pin enabled after reset");
  COV_CTRL: cover property (wq_reg && aq_reg == dsp_pkg::ADDR_CTRL);
  COV_READ: cover property (rd);
  COV_EDGE: cover property ($rose(compare_output_a));
endmodule : dsp_pwm16_chk
bind dsp_pwm16 dsp_pwm16_chk u_dsp_pwm16_chk (.clk_sys, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .compare_output_a,
  .compare_output_a_oe_n, .compare_output_b, .compare_output_b_oe_n);

// >>> tb/test_dual_slope_pwm_16bit.sv
// Purpose: Bench for the dual-slope PWM block
// Assumes: Single AHB-Lite transfers, read data taken at the edge ending the data phase
// Notes: Widths measured on the loaded pin
`timescale 1ns/1ps
module test_dual_slope_pwm_16bit;
  typedef struct {logic [3:0] w; logic [1:0] com; logic [15:0] top, c; logic [2:0] cs;
    logic dir; int hi, lo;} dsp_case_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q, cw;
  logic hreadyout, hresp, hready, oa, oa_n, ob, ob_n, pin_a, pin_b;
  int fails = 0;
  int checks_done = 0;
  int hi, lo;
  dsp_case_t k;
  // Mode, output mode, top, compare, clock select, direction, high, low
  dsp_case_t tab [10] = '{
    '{4'hA, 2'h2, 16'h0014, 16'h0005, 3'h1, 1'b1, 10, 30},
    '{4'h8, 2'h2, 16'h0014, 16'h0005, 3'h1, 1'b1, 10, 30},
    '{4'hA, 2'h3, 16'h0014, 16'h0005, 3'h1, 1'b1, 30, 10},
    '{4'hB, 2'h2, 16'h0000, 16'h000C, 3'h1, 1'b1, 200, 0},
    '{4'h9, 2'h2, 16'h0000, 16'h000C, 3'h1, 1'b1, 200, 0},
    '{4'h1, 2'h2, 16'h0000, 16'h0040, 3'h1, 1'b1, 128, 382},
    '{4'hA, 2'h2, 16'h0006, 16'h0002, 3'h2, 1'b1, 32, 64},
    '{4'h8, 2'h1, 16'h0014, 16'h000A, 3'h1, 1'b1, 20, 20},
    '{4'hA, 2'h2, 16'h0014, 16'h0000, 3'h1, 1'b1, 0, 0},
    '{4'hA, 2'h2, 16'h0014, 16'h0005, 3'h1, 1'b0, 0, 0}};
  logic [15:0] msk [3] = '{dsp_pkg::TOP_8BIT, dsp_pkg::TOP_9BIT, dsp_pkg::TOP_10BIT};
  assign hready = hreadyout;
  always #5 clk_sys = ~clk_sys;
  dsp_pwm16 u_dsp_pwm16 (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hrdata, .hreadyout, .hresp, .hready, .compare_output_a(oa), .compare_output_a_oe_n(oa_n),
    .compare_output_b(ob), .compare_output_b_oe_n(ob_n));
  dsp_load u_dsp_load (.out_a(oa), .out_a_oe_n(oa_n), .out_b(ob), .out_b_oe_n(ob_n), .pin_a,
    .pin_b);
  task end_sim;
    $display("mismatches %0d of %0d checks", fails, checks_done);
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task run(input logic v, output int c);
    c = 0;
    while (pin_a === v || c == 0) begin
      @(posedge clk_sys);
      c++;
      if (c > 3000) begin
        fails++;
        end_sim;
      end
    end
  endtask : run
  task wait_rdy;
    int n;
    n = 0;
    while (hready !== 1'b1) begin
      @(posedge clk_sys);
      n++;
      if (n > 100) begin
        fails++;
        end_sim;
      end
    end
  endtask : wait_rdy
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge clk_sys);
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    wait_rdy;
    q = hrdata;
  endtask : bus
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(8'h18, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    foreach (msk[i]) begin
      bus(dsp_pkg::ADDR_CTRL, 1'b1, 32'(i + 1));
      bus(dsp_pkg::ADDR_CMPA, 1'b1, 32'hFFFF);
      bus(dsp_pkg::ADDR_CMPA, 1'b0, 32'h0);
      chk("compare_a_value", {16'h0, msk[i]}, q);
    end
    bus(dsp_pkg::ADDR_CTRL, 1'b1, {28'h0, dsp_pkg::WGM_PC_CAP});
    bus(dsp_pkg::ADDR_CAPT, 1'b1, 32'h1234);
    bus(dsp_pkg::ADDR_CAPT, 1'b0, 32'h0);
    chk("capture_top_value", 32'h1234, q);
    foreach (tab[i]) begin
      k = tab[i];
      cw = {19'h0, k.dir, 1'b0, dsp_pkg::CS_STOP, 2'h0, k.com, k.w};
      bus(dsp_pkg::ADDR_CTRL, 1'b1, cw);
      bus(dsp_pkg::ADDR_CNT, 1'b1, 32'h0);
      bus(dsp_pkg::ADDR_CAPT, 1'b1, {16'h0, k.top});
      bus(dsp_pkg::ADDR_CMPA, 1'b1, {16'h0, k.c});
      bus(dsp_pkg::ADDR_CMPB, 1'b1, 32'h3);
      cw[10:8] = k.cs;
      bus(dsp_pkg::ADDR_CTRL, 1'b1, cw);
      repeat (600) @(posedge clk_sys);
      lo = 0;
      if (k.lo == 0) begin
        hi = 0;
        repeat (200) begin
          @(posedge clk_sys);
          if (pin_a === 1'b1) hi++;
        end
      end else begin
        run(1'b1, hi);
        run(1'b0, hi);
        run(1'b1, hi);
        run(1'b0, lo);
      end
      chk("pin_a high", k.hi, hi);
      chk("pin_a low", k.lo, lo);
      if (i < 2) begin
        bus(dsp_pkg::ADDR_FLAG, 1'b1, 32'hF);
        repeat (100) @(posedge clk_sys);
        bus(dsp_pkg::ADDR_FLAG, 1'b0, 32'h0);
        chk("flags", 32'hF, q);
        cw[10:8] = dsp_pkg::CS_STOP;
        bus(dsp_pkg::ADDR_CTRL, 1'b1, cw);
        bus(dsp_pkg::ADDR_FLAG, 1'b1, 32'hF);
        bus(dsp_pkg::ADDR_FLAG, 1'b0, 32'h0);
        chk("flags cleared", 32'h0, q);
      end
    end
    end_sim;
  end
endmodule : test_dual_slope_pwm_16bit
